// ### verilog/boundary_scan_port.v
`timescale 1ns/1ps
`default_nettype none

`include "scan_port_defines.vh"

module boundary_scan_port #(
  parameter NUM_IN            = 8,
  parameter NUM_OUT           = 8,
  parameter [3:0]  REVISION   = 4'h1,  // Arbitrary value
  parameter [15:0] PART_CODE  = 16'h0C5A,  // Arbitrary value
  parameter [10:0] VENDOR     = 11'h05B  // Arbitrary value
) (
  input  wire               clock_i,
  input  wire               rst_b_i,
  input  wire               test_clk_i,
  input  wire               test_mode_i,
  input  wire               test_data_i,
  input  wire               test_rst_b_i,
  output wire               test_data_o,
  output wire               test_data_oe_o,
  input  wire [NUM_IN-1:0]  func_in_i,
  input  wire [NUM_OUT-1:0] core_out_i,
  input  wire               core_oe_i,
  output wire [NUM_OUT-1:0] pad_out_o,
  output wire               pad_oe_o
);

  localparam CHAIN_LEN = NUM_IN + NUM_OUT;

  localparam [3:0] ST_RESET      = 4'h0;
  localparam [3:0] ST_IDLE       = 4'h1;
  localparam [3:0] ST_SEL_DR     = 4'h2;
  localparam [3:0] ST_CAP_DR     = 4'h3;
  localparam [3:0] ST_SHIFT_DR   = 4'h4;
  localparam [3:0] ST_EXIT1_DR   = 4'h5;
  localparam [3:0] ST_PAUSE_DR   = 4'h6;
  localparam [3:0] ST_EXIT2_DR   = 4'h7;
  localparam [3:0] ST_UPDATE_DR  = 4'h8;
  localparam [3:0] ST_SEL_IR     = 4'h9;
  localparam [3:0] ST_CAP_IR     = 4'hA;
  localparam [3:0] ST_SHIFT_IR   = 4'hB;
  localparam [3:0] ST_EXIT1_IR   = 4'hC;
  localparam [3:0] ST_PAUSE_IR   = 4'hD;
  localparam [3:0] ST_EXIT2_IR   = 4'hE;
  localparam [3:0] ST_UPDATE_IR  = 4'hF;

  // ----------------------------------------
  // Controller next state
  // ----------------------------------------
  function [3:0] tap_next;
    input [3:0] st;
    input       tms;
    begin
      case (st)
        ST_RESET:     tap_next = tms ? ST_RESET   : ST_IDLE;
        ST_IDLE:      tap_next = tms ? ST_SEL_DR  : ST_IDLE;
        ST_SEL_DR:    tap_next = tms ? ST_SEL_IR  : ST_CAP_DR;
        ST_CAP_DR:    tap_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_SHIFT_DR:  tap_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_EXIT1_DR:  tap_next = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
        ST_PAUSE_DR:  tap_next = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
        ST_EXIT2_DR:  tap_next = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
        ST_UPDATE_DR: tap_next = tms ? ST_SEL_DR  : ST_IDLE;
        ST_SEL_IR:    tap_next = tms ? ST_RESET   : ST_CAP_IR;
        ST_CAP_IR:    tap_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_SHIFT_IR:  tap_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_EXIT1_IR:  tap_next = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
        ST_PAUSE_IR:  tap_next = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
        ST_EXIT2_IR:  tap_next = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
        ST_UPDATE_IR: tap_next = tms ? ST_SEL_DR  : ST_IDLE;
        default:      tap_next = ST_RESET;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reg  rst_meta_reg;
  reg  rst_sync_reg;
  wire rst_b;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_b = rst_sync_reg;

  // ----------------------------------------
  // Test pin sampling
  // ----------------------------------------
  wire [3:0] pins;
  wire       tck;
  wire       tdi;
  wire       tms;
  wire       trst_b;
  reg        tck_prev_reg;
  wire       tck_rise;
  wire       tck_fall;

  pin_sync #(
    .WIDTH   (4),
    .RST_VAL (`PIN_SYNC_RESET)
  ) u_pin_sync (
    .clock_i (clock_i),
    .rst_b_i (rst_b),
    .pin_i   ({test_rst_b_i, test_mode_i, test_data_i, test_clk_i}),
    .level_o (pins)
  );

  assign tck    = pins[0];
  assign tdi    = pins[1];
  assign tms    = pins[2];
  assign trst_b = pins[3];

  always @(posedge clock_i or negedge rst_b) begin
    if (!rst_b) begin
      tck_prev_reg <= 1'b0;
    end else begin
      tck_prev_reg <= tck;
    end
  end

  assign tck_rise = tck & ~tck_prev_reg;
  assign tck_fall = ~tck & tck_prev_reg;

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  reg  [3:0]           tap_state_reg;
  reg  [`INSTR_WIDTH-1:0] instruction_shift_reg;
  reg  [`INSTR_WIDTH-1:0] active_instr_reg;
  reg                  single_bit_pass_reg;
  reg  [`ID_WIDTH-1:0] identification_shift_reg;
  reg  [CHAIN_LEN-1:0] boundary_cell_chain;
  reg  [NUM_OUT-1:0]   cell_update_reg;
  reg                  tdo_reg;
  reg                  tdo_oe_reg;
  reg  [NUM_OUT-1:0]   pad_out_reg;
  reg                  pad_oe_reg;
  wire                 sel_chain;
  wire                 sel_ident;
  wire                 drive_cells;
  wire                 float_outputs;
  wire [`ID_WIDTH-1:0] ident_value;
  reg                  dr_serial_out;

  // Chain selected for extest and sample
  assign sel_chain = (active_instr_reg == `OP_EXTEST) ||
                     (active_instr_reg == `OP_SAMPLE_PRELOAD);
  assign sel_ident = (active_instr_reg == `OP_IDENTIFY_PART);
  assign drive_cells = (active_instr_reg == `OP_EXTEST) ||
                       (active_instr_reg == `OP_CLAMP);
  assign float_outputs = (active_instr_reg == `OP_FLOAT_OUTPUTS);

  assign ident_value[`ID_REV_MSB:`ID_REV_LSB]       = REVISION;
  assign ident_value[`ID_PART_MSB:`ID_PART_LSB]     = PART_CODE;
  assign ident_value[`ID_VENDOR_MSB:`ID_VENDOR_LSB] = VENDOR;
  assign ident_value[`ID_PRESENT_BIT]               = 1'b1;

  // Everything else uses the bypass bit
  always @* begin
    if (sel_chain) begin
      dr_serial_out = boundary_cell_chain[0];
    end else if (sel_ident) begin
      dr_serial_out = identification_shift_reg[0];
    end else begin
      dr_serial_out = single_bit_pass_reg;
    end
  end

  // ----------------------------------------
  // Controller and scan registers
  // ----------------------------------------
  always @(posedge clock_i or negedge rst_b) begin
    if (!rst_b) begin
      tap_state_reg            <= ST_RESET;
      instruction_shift_reg    <= `OP_CAPTURE_PATTERN;
      active_instr_reg         <= `OP_IDENTIFY_PART;
      single_bit_pass_reg      <= 1'b0;
      identification_shift_reg <= {`ID_WIDTH{1'b0}};
      boundary_cell_chain      <= {CHAIN_LEN{1'b0}};
      cell_update_reg          <= {NUM_OUT{1'b0}};
    end else if (!trst_b) begin
      tap_state_reg    <= ST_RESET;
      active_instr_reg <= `OP_IDENTIFY_PART;
    end else if (tck_rise) begin
      tap_state_reg <= tap_next(tap_state_reg, tms);
      case (tap_state_reg)
        ST_RESET: begin
          active_instr_reg <= `OP_IDENTIFY_PART;
        end
        ST_CAP_IR: begin
          instruction_shift_reg <= `OP_CAPTURE_PATTERN;
        end
        ST_SHIFT_IR: begin
          instruction_shift_reg <= {tdi, instruction_shift_reg[`INSTR_WIDTH-1:1]};
        end
        ST_UPDATE_IR: begin
          active_instr_reg <= instruction_shift_reg;
        end
        ST_CAP_DR: begin
          single_bit_pass_reg <= 1'b0;
          if (sel_ident) begin
            identification_shift_reg <= ident_value;
          end
          if (sel_chain) begin
            boundary_cell_chain <= {func_in_i, pad_out_reg};
          end
        end
        ST_SHIFT_DR: begin
          single_bit_pass_reg <= tdi;
          if (sel_ident) begin
            identification_shift_reg <= {tdi, identification_shift_reg[`ID_WIDTH-1:1]};
          end
          if (sel_chain) begin
            boundary_cell_chain <= {tdi, boundary_cell_chain[CHAIN_LEN-1:1]};
          end
        end
        ST_UPDATE_DR: begin
          if (sel_chain) begin
            cell_update_reg <= boundary_cell_chain[NUM_OUT-1:0];
          end
        end
        default: begin
          single_bit_pass_reg <= single_bit_pass_reg;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Serial output on falling edge
  // ----------------------------------------
  // Output changes on falling test clock
  always @(posedge clock_i or negedge rst_b) begin
    if (!rst_b) begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_reg <= (tap_state_reg == ST_SHIFT_IR) || (tap_state_reg == ST_SHIFT_DR);
      tdo_reg    <= (tap_state_reg == ST_SHIFT_IR) ? instruction_shift_reg[0]
                                                  : dr_serial_out;
    end
  end

  // ----------------------------------------
  // Functional output control
  // ----------------------------------------
  // All functional outputs boundary controlled
  always @(posedge clock_i or negedge rst_b) begin
    if (!rst_b) begin
      pad_out_reg <= {NUM_OUT{1'b0}};
      pad_oe_reg  <= 1'b0;
    end else begin
      pad_out_reg <= drive_cells ? cell_update_reg : core_out_i;
      pad_oe_reg  <= float_outputs ? 1'b0 : (drive_cells | core_oe_i);
    end
  end

  assign test_data_o    = tdo_reg;
  assign test_data_oe_o = tdo_oe_reg;
  assign pad_out_o      = pad_out_reg;
  assign pad_oe_o       = pad_oe_reg;

endmodule

`default_nettype wire

// ### verilog/scan_port_defines.vh
`ifndef SCAN_PORT_DEFINES_VH
`define SCAN_PORT_DEFINES_VH

// ----------------------------------------
// Register sizes
// ----------------------------------------
`define INSTR_WIDTH        4
`define ID_WIDTH           32

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define OP_EXTEST          4'h0
`define OP_SAMPLE_PRELOAD  4'h1
`define OP_IDENTIFY_PART   4'h2
`define OP_FLOAT_OUTPUTS   4'h3
`define OP_CLAMP           4'h8
`define OP_CAPTURE_PATTERN 4'hD
`define OP_BYPASS          4'hF

// ----------------------------------------
// Identification field positions
// ----------------------------------------
`define ID_REV_MSB         31
`define ID_REV_LSB         28
`define ID_PART_MSB        27
`define ID_PART_LSB        12
`define ID_VENDOR_MSB      11
`define ID_VENDOR_LSB      1
`define ID_PRESENT_BIT     0

// ----------------------------------------
// Pin synchroniser reset levels
// ----------------------------------------
`define PIN_SYNC_RESET     4'hC

`endif

// ### verilog/pin_sync.v
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter WIDTH               = 4,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             clock_i,
  input  wire             rst_b_i,
  input  wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] level_o
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;
  reg [WIDTH-1:0] stage3_reg;
  reg [WIDTH-1:0] level_reg;
  wire [WIDTH-1:0] agree;

  // ----------------------------------------
  // Three stages, accept when two agree
  // ----------------------------------------
  assign agree = ~(stage2_reg ^ stage3_reg);

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage1_reg <= RST_VAL;
      stage2_reg <= RST_VAL;
      stage3_reg <= RST_VAL;
      level_reg  <= RST_VAL;
    end else begin
      stage1_reg <= pin_i;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      level_reg  <= (agree & stage3_reg) | (~agree & level_reg);
    end
  end

  assign level_o = level_reg;

endmodule

`default_nettype wire

// ### dv/boundary_scan_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_port_props #(
  parameter int NUM_OUT = 8
) (
  input wire logic               clock_i,
  input wire logic               rst_b_i,
  input wire logic               test_clk_i,
  input wire logic               test_rst_b_i,
  input wire logic               test_data_o,
  input wire logic               test_data_oe_o,
  input wire logic [NUM_OUT-1:0] core_out_i,
  input wire logic               core_oe_i,
  input wire logic [NUM_OUT-1:0] pad_out_o,
  input wire logic               pad_oe_o
);
  // ----------------------------------------
  // Edge age counters and reset settle counter
  // ----------------------------------------
  logic       tck_q;
  logic [3:0] fall_cnt;
  logic [3:0] rise_cnt;
  logic [3:0] settle_cnt;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tck_q <= 1'h0;
      fall_cnt <= 4'hF;
      rise_cnt <= 4'hF;
      settle_cnt <= 4'h0;
    end else begin
      tck_q <= test_clk_i;
      fall_cnt <= (tck_q && !test_clk_i) ? 4'h0 : fall_cnt + {3'h0, fall_cnt != 4'hF};
      rise_cnt <= (!tck_q && test_clk_i) ? 4'h0 : rise_cnt + {3'h0, rise_cnt != 4'hF};
      settle_cnt <= settle_cnt + {3'h0, settle_cnt != 4'hF};
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_trst_held;
    !test_rst_b_i [*8];
  endsequence
  sequence s_oe_up;
    $rose(test_data_oe_o);
  endsequence
  property p_tdo_edge;
    $changed(test_data_o) && test_rst_b_i |-> fall_cnt inside {[1:7]};
  endproperty
  a_tdo_edge: assert property (p_tdo_edge) else $error("serial out moved off a falling edge");
  property p_tdoe_edge;
    $changed(test_data_oe_o) && test_rst_b_i |-> fall_cnt inside {[1:7]};
  endproperty
  a_tdoe_edge: assert property (p_tdoe_edge) else $error("serial enable moved off a fall");
  property p_oe_hold;
    s_oe_up |-> test_data_oe_o [*7];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("serial enable shorter than a bit");
  property p_pad_src;
    $changed(pad_out_o) && test_rst_b_i && settle_cnt > 4'h4
      |-> rise_cnt inside {[1:8]} || $past(core_out_i) != $past(core_out_i, 2);
  endproperty
  a_pad_src: assert property (p_pad_src) else $error("pad data moved without cause");
  property p_padoe_src;
    $changed(pad_oe_o) && test_rst_b_i && settle_cnt > 4'h4
      |-> rise_cnt inside {[1:8]} || $past(core_oe_i) != $past(core_oe_i, 2);
  endproperty
  a_padoe_src: assert property (p_padoe_src) else $error("pad enable moved without cause");
  property p_trst_oe;
    s_trst_held |-> !test_data_oe_o;
  endproperty
  a_trst_oe: assert property (p_trst_oe) else $error("serial enable high in test reset");
  property p_trst_pads;
    s_trst_held |-> pad_out_o == $past(core_out_i) && pad_oe_o == $past(core_oe_i);
  endproperty
  a_trst_pads: assert property (p_trst_pads) else $error("pads not normal in test reset");
  property p_rst_quiet;
    $rose(rst_b_i) |-> !pad_oe_o && !test_data_oe_o && !test_data_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active at reset release");
endmodule
bind boundary_scan_port boundary_scan_port_props #(.NUM_OUT(NUM_OUT)) props_inst (
  .clock_i, .rst_b_i, .test_clk_i, .test_rst_b_i, .test_data_o, .test_data_oe_o,
  .core_out_i, .core_oe_i, .pad_out_o, .pad_oe_o);
`default_nettype wire

// ### dv/scan_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module scan_ctrl_model (
  input  wire logic tdo_i,
  output var  logic tck_o,
  output var  logic tms_o,
  output var  logic tdi_o
);
  initial begin
    tck_o = 1'h0;
    tms_o = 1'h1;
    tdi_o = 1'h0;
  end
  task automatic step(input logic m, input logic b, output logic q);
    tms_o = m;
    tdi_o = b;
    #80 tck_o = 1'h1;
    #80 q = tdo_i;
    tck_o = 1'h0;
    tdi_o = ~b;
  endtask
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    #(27 - ($time % 20));
    step(1'h0, 1'h0, q);
    step(1'h1, 1'h0, q);
    if (ir) step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
    step(1'h0, 1'h0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
  endtask
endmodule
`default_nettype wire

// ### dv/tb_boundary_scan_port.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp=%0h got=%0h", n, e, g); end end
module tb_boundary_scan_port;
  // Arbitrary identity values
  localparam logic [3:0]  REV = 4'h5;
  localparam logic [15:0] PART = 16'h3C3C;
  localparam logic [10:0] VEND = 11'h155;
  localparam logic [3:0]  CODES [6] = '{4'h8, 4'h3, 4'hF, 4'hF, 4'h3, 4'h8};
  logic        clock_i = 1'h0;
  logic        rst_b_i = 1'h0;
  logic        test_rst_b_i = 1'h1;
  logic [7:0]  func_in_i = 8'h00;
  logic [7:0]  core_out_i = 8'h00;
  logic        core_oe_i = 1'h0;
  logic        tck, tms, tdi, tdo, tdo_oe, pad_oe;
  logic        oe_seen = 1'h0;
  logic [7:0]  pad_out, cells;
  logic [31:0] d, din;
  int          miscompares = 0;
  int          total_checks = 0;
  int          seed = 61128;
  scan_ctrl_model scan_ctrl_model_inst (.tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
  boundary_scan_port #(.REVISION(REV), .PART_CODE(PART), .VENDOR(VEND)) boundary_scan_port_inst (
    .clock_i, .rst_b_i, .test_clk_i(tck), .test_mode_i(tms), .test_data_i(tdi), .test_rst_b_i,
    .test_data_o(tdo), .test_data_oe_o(tdo_oe), .func_in_i, .core_out_i, .core_oe_i,
    .pad_out_o(pad_out), .pad_oe_o(pad_oe));
  always #10 clock_i = ~clock_i;
  // Serial enable seen at least once
  always @(posedge clock_i) begin
    if (tdo_oe === 1'h1) begin
      oe_seen <= 1'h1;
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic new_pins();
    @(posedge clock_i);
    func_in_i <= 8'($random(seed));
    core_out_i <= 8'($random(seed));
    core_oe_i <= 1'($random(seed));
    repeat (3) @(posedge clock_i);
  endtask
  task automatic scan(input logic ir, input int n);
    din = $random(seed);
    scan_ctrl_model_inst.scan(ir, n, din, d);
    repeat (8) @(negedge clock_i);
  endtask
  task automatic load(input logic [3:0] code);
    scan_ctrl_model_inst.scan(1'h1, 4, {28'h0, code}, d);
    repeat (8) @(negedge clock_i);
    `CHECK("capture_ir", 4'hD, d[3:0])
  endtask
  task automatic pads_follow();
    `CHECK("pad_out", core_out_i, pad_out)
    `CHECK("pad_oe", core_oe_i, pad_oe)
  endtask
  task automatic id_check();
    scan(1'h0, 32);
    `CHECK("id", {REV, PART, VEND, 1'h1}, d)
    `CHECK("oe_idle", 1'h0, tdo_oe)
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'h1;
    repeat (6) @(posedge clock_i);
    id_check();
    new_pins();
    load(4'h1);
    pads_follow();
    scan(1'h0, 16);
    `CHECK("sample", {func_in_i, core_out_i}, d[15:0])
    cells = din[7:0];
    load(4'h0);
    `CHECK("extest_out", cells, pad_out)
    `CHECK("extest_oe", 1'h1, pad_oe)
    new_pins();
    scan(1'h0, 16);
    `CHECK("extest_cap", {func_in_i, cells}, d[15:0])
    cells = din[7:0];
    `CHECK("extest_upd", cells, pad_out)
    foreach (CODES[i]) begin
      new_pins();
      load(CODES[i]);
      scan(1'h0, 8);
      `CHECK("bypass", {din[6:0], 1'h0}, d[7:0])
      if (CODES[i] == 4'h8) begin
        `CHECK("clamp_out", cells, pad_out)
        `CHECK("clamp_oe", 1'h1, pad_oe)
      end else if (CODES[i] == 4'h3) begin
        `CHECK("float_oe", 1'h0, pad_oe)
      end else begin
        pads_follow();
      end
    end
    load(4'h2);
    id_check();
    load(4'h0);
    @(posedge clock_i);
    test_rst_b_i <= 1'h0;
    repeat (10) @(posedge clock_i);
    test_rst_b_i <= 1'h1;
    repeat (4) @(posedge clock_i);
    pads_follow();
    id_check();
    load(4'h0);
    @(posedge clock_i);
    rst_b_i <= 1'h0;
    repeat (3) @(posedge clock_i);
    `CHECK("rst_oe", 1'h0, pad_oe)
    rst_b_i <= 1'h1;
    repeat (6) @(posedge clock_i);
    id_check();
    `CHECK("oe_seen", 1'h1, oe_seen)
    report_and_stop();
  end
  initial begin
    #1_000_000;
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
